/* hw/sleep_ctrl_defines.vh */
// constants for the sleep-mode power controller
`ifndef SLEEP_CTRL_DEFINES_VH
`define SLEEP_CTRL_DEFINES_VH

`define MODE_IDLE        3'h0
`define MODE_ADC_NR      3'h1
`define MODE_POWER_DOWN  3'h2
`define MODE_POWER_SAVE  3'h3
`define MODE_RSVD_4      3'h4
`define MODE_RSVD_5      3'h5
`define MODE_STANDBY     3'h6
`define MODE_EXT_STANDBY 3'h7

`define CORE_CTRL_BOD_OFF_BIT 6
`define CORE_CTRL_RESET       8'h00

`define HALT_AFTER_WAKE_CYC  4
`define STANDBY_WAKE_CYC     6
`define CLK_PERIOD_NS        10
`define BOD_WAKE_TIME_NS     60000
`define BOD_WAKE_CYC         ((`BOD_WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_DEFAULT_CYC  16

`define TIMED_WINDOW_CYC     4

`endif

/* hw/wake_counter.v */
// down counter that times a wake-up delay
`timescale 1ns/1ps
`include "sleep_ctrl_defines.vh"

module wake_counter #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  output reg              done
);
  reg [WIDTH-1:0] count_q;
  reg             busy_q;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= {WIDTH{1'b0}};
      busy_q  <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        count_q <= loadValue;
        busy_q  <= 1'b1;
      end
      else if (busy_q)
      begin
        if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
        else
          count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* hw/bod_sleep_bit.v */
// brown-out sleep-off bit with its timed write guard
`timescale 1ns/1ps
`include "sleep_ctrl_defines.vh"

module bod_sleep_bit (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire guardWrite,
  input  wire bitWrite,
  input  wire bitValue,
  input  wire clearBit,
  output reg  brownoutSleepOff
);
  reg [2:0] window_q;

  localparam WINDOW_CYC = `TIMED_WINDOW_CYC;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      window_q         <= 3'h0;
      brownoutSleepOff <= 1'b0;
    end
    else
    begin
      if (guardWrite)
        window_q <= WINDOW_CYC[2:0];
      else if (window_q != 3'h0)
        window_q <= window_q - 3'h1;
      // writes outside the window are dropped
      if (bitWrite && (window_q != 3'h0))
        brownoutSleepOff <= bitValue;
      else if (clearBit)
        brownoutSleepOff <= 1'b0;
    end
  end
endmodule

/* hw/sleep_mode_power_controller.v */
// sleep-mode controller: clock gating, oscillator stop, wake-up sequencing
// Functional notes
// - after interrupt wake, core stays halted four cycles beyond start-up time.
// - register file and static memory keep contents; their clocks only pause.
// - reset during sleep wakes the device and restarts at the reset vector.
// - requested brown-out disable acts on sleep entry, re-enabled on wake.
// - wake-up extended to about 60 us when detector was off.
// - bit 6 of core control selects brown-out off in sleep, reset zero.
// - brown-out sleep bit accepted only inside guarded timed write sequence.
// - brown-out disable only in power-down, power-save, standby, extended standby.
// - idle stops core and flash clocks, others and main oscillator run.
// - idle wakes on any enabled interrupt.
// - entering idle or ADC noise reduction starts conversion if ADC enabled.
// - ADC noise reduction stops peripheral, core, flash clocks.
// - ADC noise reduction wakes only from listed sources.
// - power-down stops oscillator and all generated clocks.
// - power-down wakes only from resets, watchdog, address match, level irq, pin change.
// - outside idle external pins wake only through level interrupts; ADC noise reduction wakes on extIrq1Level only, not extIrq0Level.
// - level gone before start-up ends: wake but raise no interrupt.
// - power-down wake waits start-up delay chosen by clock-select fuses.
// - power-save as power-down but asynchronous timer keeps running when asyncTimerAsyncClk is set.
// - power-save timer wake needs timer irq enable and global enable.
// - power-save stops unused timer oscillator or main clock.
// - standby is power-down with main oscillator running; six-cycle wake.
// - extended standby is power-save with main oscillator running; six-cycle wake.
`timescale 1ns/1ps
`include "sleep_ctrl_defines.vh"

module sleep_mode_power_controller #(
  parameter STARTUP_CYC = `STARTUP_DEFAULT_CYC,
  parameter BOD_CYC     = `BOD_WAKE_CYC,
  parameter CNT_W       = 16
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             sleepEnable,
  input  wire [2:0]       sleepModeSelect,
  input  wire             sleepInstr,
  input  wire             bodGuardWrite,
  input  wire             bodBitWrite,
  input  wire             bodBitValue,
  input  wire [CNT_W-1:0] startupTimeFuses,
  input  wire             globalIrqEnable,
  input  wire             anyIrqPending,
  input  wire             adcDone,
  input  wire             adcEnabled,
  input  wire             twoWireAddrMatch,
  input  wire             asyncTimerIrq,
  input  wire             asyncTimerIrqMask,
  input  wire             asyncTimerAsyncClk,
  input  wire             asyncTimerSyncClk,
  input  wire             nvmReady,
  input  wire             extIrq0Level,
  input  wire             extIrq1Level,
  input  wire             extIrq0Edge,
  input  wire             extIrq1Edge,
  input  wire             pinChange,
  input  wire             watchdogIrq,
  input  wire             resetEvent,
  output reg              coreClockEn,
  output reg              programMemoryClockEn,
  output reg              peripheralClockEn,
  output reg              converterClockEn,
  output reg              asyncTimerClockEn,
  output reg              mainOscEn,
  output reg              timerOscEn,
  output reg              brownoutEnable,
  output reg              adcStartConv,
  output reg              coreHalted,
  output reg              takeIrq,
  output reg              jumpResetVector,
  output reg              suppressExtIrq,
  output reg              brownoutSleepOffOut
);
  localparam ST_RUN   = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_HALT  = 3'h3;

  // timing counts are cut to the counter widths where they are used
  localparam STANDBY_CYC = `STANDBY_WAKE_CYC;
  localparam HALT_CYC    = `HALT_AFTER_WAKE_CYC;

  reg [2:0]       state_q;
  reg [2:0]       mode_q;
  reg             bodOff_q;
  reg             isReset_q;
  reg             levelWake_q;
  reg             dropIrq_q;
  reg [2:0]       halt_q;
  reg             loadCnt;
  reg [CNT_W-1:0] loadVal;
  wire            cntDone;
  wire            bodBit;
  reg             wakeEv;
  reg             levelEv;

  function deep;
    input [2:0] m;
    begin
      deep = (m == `MODE_POWER_DOWN) || (m == `MODE_POWER_SAVE) ||
             (m == `MODE_STANDBY) || (m == `MODE_EXT_STANDBY);
    end
  endfunction

  function saveLike;
    input [2:0] m;
    begin
      saveLike = (m == `MODE_POWER_SAVE) || (m == `MODE_EXT_STANDBY);
    end
  endfunction

  // standby flavours keep the main oscillator, so they wake on a short fixed count
  function sbLike;
    input [2:0] m;
    begin
      sbLike = (m == `MODE_STANDBY) || (m == `MODE_EXT_STANDBY);
    end
  endfunction

  bod_sleep_bit u_bod (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .guardWrite       (bodGuardWrite),
    .bitWrite         (bodBitWrite),
    .bitValue         (bodBitValue),
    .clearBit         (1'b0),
    .brownoutSleepOff (bodBit)
  );

  wake_counter #(.WIDTH(CNT_W)) u_cnt (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .load      (loadCnt),
    .loadValue (loadVal),
    .done      (cntDone)
  );

  // wake sources per mode
  always @*
  begin
    levelEv = extIrq0Level || extIrq1Level;
    wakeEv  = 1'b0;
    case (mode_q)
      `MODE_IDLE:
        wakeEv = anyIrqPending || extIrq0Edge || extIrq1Edge || levelEv || pinChange;
      `MODE_ADC_NR:
        wakeEv = adcDone || watchdogIrq || twoWireAddrMatch || asyncTimerIrq || nvmReady ||
                 extIrq1Level || pinChange;
      `MODE_POWER_DOWN, `MODE_STANDBY:
        wakeEv = watchdogIrq || twoWireAddrMatch || levelEv || pinChange;
      `MODE_POWER_SAVE, `MODE_EXT_STANDBY:
        wakeEv = watchdogIrq || twoWireAddrMatch || levelEv || pinChange ||
                 (asyncTimerIrq && asyncTimerIrqMask && globalIrqEnable);
      default:
        wakeEv = 1'b0;
    endcase
  end

  // wake delay selection
  always @*
  begin
    loadCnt = 1'b0;
    loadVal = {CNT_W{1'b0}};
    if (state_q == ST_SLEEP && (wakeEv || resetEvent))
    begin
      loadCnt = 1'b1;
      // a cut detector needs the long settle time whatever the mode
      if (bodOff_q)
        loadVal = BOD_CYC[CNT_W-1:0];
      else if (sbLike(mode_q))
        loadVal = STANDBY_CYC[CNT_W-1:0];
      else if (deep(mode_q))
        loadVal = (startupTimeFuses == {CNT_W{1'b0}}) ? STARTUP_CYC[CNT_W-1:0] : startupTimeFuses;
      else
        loadVal = {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q              <= ST_RUN;
      mode_q               <= `MODE_IDLE;
      bodOff_q             <= 1'b0;
      isReset_q            <= 1'b0;
      levelWake_q          <= 1'b0;
      dropIrq_q            <= 1'b0;
      halt_q               <= 3'h0;
      coreClockEn          <= 1'b1;
      programMemoryClockEn <= 1'b1;
      peripheralClockEn    <= 1'b1;
      converterClockEn     <= 1'b1;
      asyncTimerClockEn    <= 1'b1;
      mainOscEn            <= 1'b1;
      timerOscEn           <= 1'b1;
      brownoutEnable       <= 1'b1;
      adcStartConv         <= 1'b0;
      coreHalted           <= 1'b0;
      takeIrq              <= 1'b0;
      jumpResetVector      <= 1'b0;
      suppressExtIrq       <= 1'b0;
      brownoutSleepOffOut  <= 1'b0;
    end
    else
    begin
      adcStartConv        <= 1'b0;
      takeIrq             <= 1'b0;
      jumpResetVector     <= 1'b0;
      suppressExtIrq      <= 1'b0;
      brownoutSleepOffOut <= bodBit;
      case (state_q)
        ST_RUN:
        begin
          // reserved codes fall through: no domain stops
          if (sleepInstr && sleepEnable && sleepModeSelect != `MODE_RSVD_4 &&
              sleepModeSelect != `MODE_RSVD_5)
          begin
            state_q     <= ST_SLEEP;
            mode_q      <= sleepModeSelect;
            coreHalted  <= 1'b1;
            // only clocks pause, so register file and memory are untouched
            coreClockEn          <= 1'b0;
            programMemoryClockEn <= 1'b0;
            peripheralClockEn    <= (sleepModeSelect == `MODE_IDLE);
            converterClockEn     <= (sleepModeSelect == `MODE_IDLE) ||
                                    (sleepModeSelect == `MODE_ADC_NR);
            asyncTimerClockEn    <= !deep(sleepModeSelect) ||
                                    (saveLike(sleepModeSelect) && asyncTimerAsyncClk);
            mainOscEn            <= !deep(sleepModeSelect) || sbLike(sleepModeSelect) ||
                                    (sleepModeSelect == `MODE_POWER_SAVE && asyncTimerSyncClk);
            timerOscEn           <= (!deep(sleepModeSelect) || saveLike(sleepModeSelect)) &&
                                    asyncTimerAsyncClk;
            if (bodBit && deep(sleepModeSelect))
            begin
              brownoutEnable <= 1'b0;
              bodOff_q       <= 1'b1;
            end
            if (adcEnabled && !deep(sleepModeSelect))
              adcStartConv <= 1'b1;
          end
        end
        ST_SLEEP:
        begin
          if (resetEvent || wakeEv)
          begin
            state_q     <= ST_START;
            isReset_q   <= resetEvent;
            levelWake_q <= levelEv && mode_q != `MODE_IDLE;
            mainOscEn   <= 1'b1;
            timerOscEn  <= asyncTimerAsyncClk;
          end
        end
        ST_START:
        begin
          if (cntDone)
          begin
            brownoutEnable       <= 1'b1;
            bodOff_q             <= 1'b0;
            peripheralClockEn    <= 1'b1;
            converterClockEn     <= 1'b1;
            asyncTimerClockEn    <= 1'b1;
            programMemoryClockEn <= 1'b1;
            dropIrq_q            <= levelWake_q && !levelEv;
            if (levelWake_q && !levelEv)
              suppressExtIrq <= 1'b1;
            if (isReset_q)
            begin
              state_q         <= ST_RUN;
              coreClockEn     <= 1'b1;
              coreHalted      <= 1'b0;
              jumpResetVector <= 1'b1;
            end
            else
            begin
              state_q <= ST_HALT;
              halt_q  <= HALT_CYC[2:0];
            end
          end
        end
        ST_HALT:
        begin
          if (halt_q <= 3'h1)
          begin
            state_q     <= ST_RUN;
            coreClockEn <= 1'b1;
            coreHalted  <= 1'b0;
            // a level that vanished during start-up wakes the core but is not serviced
            takeIrq     <= !dropIrq_q;
          end
          else
            halt_q <= halt_q - 3'h1;
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end
endmodule

/* verification/sleep_ctrl_asserts.sv */
// concurrent checks on the sleep controller ports
`timescale 1ns/1ps
module sleep_ctrl_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       sleepEnable,
  input wire logic [2:0] sleepModeSelect,
  input wire logic       sleepInstr,
  input wire logic       adcEnabled,
  input wire logic       coreClockEn,
  input wire logic       programMemoryClockEn,
  input wire logic       peripheralClockEn,
  input wire logic       converterClockEn,
  input wire logic       asyncTimerClockEn,
  input wire logic       mainOscEn,
  input wire logic       brownoutEnable,
  input wire logic       adcStartConv,
  input wire logic       coreHalted,
  input wire logic       takeIrq
);
  logic go;
  // a request only counts while the core is really running
  assign go = sleepInstr && sleepEnable && coreClockEn && !coreHalted;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_idle_gates:
    assert property (go && sleepModeSelect == 3'h0 |=> !coreClockEn && !programMemoryClockEn
      && peripheralClockEn && converterClockEn && mainOscEn) else $error("idle gating wrong");
  chk_adc_gates:
    assert property (go && sleepModeSelect == 3'h1 |=> !coreClockEn && !peripheralClockEn
      && converterClockEn && mainOscEn) else $error("noise reduction gating wrong");
  chk_pd_gates:
    assert property (go && sleepModeSelect == 3'h2 |=> !mainOscEn && !converterClockEn
      && !asyncTimerClockEn) else $error("power-down gating wrong");
  chk_sb_gates:
    assert property (go && sleepModeSelect == 3'h6 |=> mainOscEn && !peripheralClockEn
      && !asyncTimerClockEn) else $error("standby gating wrong");
  chk_rsvd_runs:
    assert property (go && sleepModeSelect[2:1] == 2'b10 |=> coreClockEn && !coreHalted)
      else $error("reserved mode slept");
  chk_adc_start:
    assert property (go && adcEnabled && sleepModeSelect[2:1] == 2'b00 |=> adcStartConv)
      else $error("conversion not started");
  chk_halt_before_irq:
    assert property (takeIrq |-> !coreHalted && $past(coreHalted) && $past(coreHalted, 4))
      else $error("irq taken without halt");
  chk_bod_light:
    assert property (!coreClockEn && converterClockEn |-> brownoutEnable)
      else $error("detector off in light sleep");
endmodule

bind sleep_mode_power_controller sleep_ctrl_asserts chk_u (.*);

/* verification/core_model.sv */
// core model: issues sleep requests and brown-out bit writes
`timescale 1ns/1ps
module core_model (
  input  wire logic  clk_sys,
  output logic       sleepEnable,
  output logic [2:0] sleepModeSelect,
  output logic       sleepInstr,
  output logic       bodGuardWrite,
  output logic       bodBitWrite,
  output logic       bodBitValue
);
  initial
  begin
    {sleepEnable, sleepModeSelect, sleepInstr} = 5'h00;
    {bodGuardWrite, bodBitWrite, bodBitValue} = 3'h0;
  end
  // enable rides with the instruction so a stray one cannot sleep
  task automatic nap_op(input logic [2:0] md);
  begin
    @(negedge clk_sys);
    sleepModeSelect = md;
    {sleepEnable, sleepInstr} = 2'h3;
    @(negedge clk_sys);
    {sleepEnable, sleepInstr} = 2'h0;
  end
  endtask
  // a gap beyond the guard window makes the write land too late
  task automatic bod_op(input logic v, input int gap);
  begin
    @(negedge clk_sys);
    bodGuardWrite = 1'b1;
    @(negedge clk_sys);
    bodGuardWrite = 1'b0;
    repeat (gap - 1) @(negedge clk_sys);
    {bodBitWrite, bodBitValue} = {1'b1, v};
    @(negedge clk_sys);
    bodBitWrite = 1'b0;
  end
  endtask
endmodule

/* verification/sleep_mode_power_controller_tb.sv */
// testbench for the sleep-mode power controller
`timescale 1ns/1ps
module sleep_mode_power_controller_tb;
  localparam logic [63:0] GATE = 64'h07027f7f05000f1f;
  logic clk_sys = 1'b0, rst_n = 1'b0, resetEvent = 1'b0, bo;
  logic sleepEnable, sleepInstr, bodGuardWrite, bodBitWrite, bodBitValue;
  logic [2:0] sleepModeSelect;
  logic [15:0] startupTimeFuses = 16'h000c;
  logic globalIrqEnable = 1'b1, asyncTimerIrqMask = 1'b0, adcEnabled = 1'b1;
  logic asyncTimerAsyncClk = 1'b1, asyncTimerSyncClk = 1'b0;
  logic nvmReady = 1'b0, extIrq1Level = 1'b0, extIrq1Edge = 1'b0, pinChange = 1'b0, watchdogIrq = 1'b0;
  logic anyIrqPending, extIrq0Level, asyncTimerIrq, twoWireAddrMatch, extIrq0Edge, adcDone;
  logic [5:0] wk = 6'h00;
  logic [1:0] fl;
  wire logic coreClockEn, programMemoryClockEn, peripheralClockEn, converterClockEn, asyncTimerClockEn;
  wire logic mainOscEn, timerOscEn, brownoutEnable, adcStartConv, coreHalted, takeIrq;
  wire logic jumpResetVector, suppressExtIrq, brownoutSleepOffOut;
  int bad_count = 0, num_checks = 0, nPd, nSb, n, m;
  assign {anyIrqPending, extIrq0Level, asyncTimerIrq, twoWireAddrMatch, extIrq0Edge, adcDone} = wk;
  always #5 clk_sys = ~clk_sys;
  sleep_mode_power_controller #(.BOD_CYC(20)) dut_u (.*);
  core_model core_u (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task automatic close_out;
  begin
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // bounded so a missing wake cannot hang the run
  task automatic wait_on(input logic rv, output int k);
  begin
    k = 0;
    while ((rv ? jumpResetVector : takeIrq) !== 1'b1 && k < 100)
    begin
      @(negedge clk_sys);
      k++;
    end
  end
  endtask
  task automatic nap(input logic [2:0] md, input logic [5:0] src, output int k);
  begin
    core_u.nap_op(md);
    @(negedge clk_sys);
    bo = brownoutEnable;
    wk = src;
    wait_on(1'b0, k);
    wk = 6'h00;
    repeat (3) @(negedge clk_sys);
  end
  endtask
  task automatic t_modes;
  begin
    for (m = 0; m < 8; m++)
    begin
      core_u.nap_op(m[2:0]);
      @(negedge clk_sys);
      check({coreClockEn, programMemoryClockEn, peripheralClockEn, converterClockEn, asyncTimerClockEn,
        mainOscEn, timerOscEn}, GATE[m*8 +: 7]);
      if (m[2:1] != 2'b10)
      begin
        resetEvent = 1'b1;
        @(negedge clk_sys);
        resetEvent = 1'b0;
        wait_on(1'b1, n);
        check(n < 100, 1'b1);
        check(takeIrq, 1'b0);
      end
      repeat (30) @(negedge clk_sys);
    end
  end
  endtask
  task automatic t_lat;
  begin
    nap(3'h0, 6'h20, n);
    check(n < 100, 1'b1);
    nap(3'h2, 6'h10, nPd);
    nap(3'h6, 6'h10, nSb);
    check(nPd - nSb, startupTimeFuses - 6);
    asyncTimerIrqMask = 1'b1;
    nap(3'h7, 6'h08, n);
    check(n, nSb);
    asyncTimerIrqMask = 1'b0;
  end
  endtask
  task automatic t_refuse;
  begin
    core_u.nap_op(3'h2);
    wk = 6'h23;
    repeat (20) @(negedge clk_sys);
    check(coreHalted, 1'b1);
    wk = 6'h04;
    wait_on(1'b0, n);
    check(n < 100, 1'b1);
    wk = 6'h00;
    {asyncTimerAsyncClk, asyncTimerSyncClk} = 2'b01;
    core_u.nap_op(3'h3);
    wk = 6'h08;
    repeat (20) @(negedge clk_sys);
    check(coreHalted, 1'b1);
    check({mainOscEn, timerOscEn, asyncTimerClockEn}, 3'b100);
    asyncTimerIrqMask = 1'b1;
    wait_on(1'b0, n);
    check(n < 100, 1'b1);
    wk = 6'h00;
    {asyncTimerAsyncClk, asyncTimerSyncClk} = 2'b10;
  end
  endtask
  task automatic t_bod;
  begin
    core_u.bod_op(1'b1, 10);
    @(negedge clk_sys);
    check(brownoutSleepOffOut, 1'b0);
    core_u.bod_op(1'b1, 1);
    @(negedge clk_sys);
    check(brownoutSleepOffOut, 1'b1);
    nap(3'h2, 6'h04, n);
    check(bo, 1'b0);
    check(n - nPd, 20 - startupTimeFuses);
    check(brownoutEnable, 1'b1);
    core_u.bod_op(1'b1, 1);
    nap(3'h0, 6'h20, n);
    check(bo, 1'b1);
  end
  endtask
  task automatic t_glitch;
  begin
    core_u.nap_op(3'h2);
    wk = 6'h10;
    @(negedge clk_sys);
    wk = 6'h00;
    fl = 2'b00;
    repeat (60)
    begin
      @(negedge clk_sys);
      fl = fl | {suppressExtIrq, takeIrq};
    end
    check({fl, coreClockEn}, 3'b101);
  end
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(brownoutSleepOffOut, 1'b0);
    t_modes();
    t_lat();
    t_refuse();
    t_bod();
    t_glitch();
    close_out();
  end
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule
